// ### core/fwff_core.sv
// How it works
// - Write enable low captures data each write edge
// - Output ready falls once first word lands
// - Almost-empty rises at empty offset plus two
// - Half-full falls at half depth plus two
// - Almost-full falls at capacity minus full offset
// - Full raises input ready, writes then ignored
// - Capacity is memory depth plus output register
// - Reads from full drop flags in order
// - Almost-empty falls at empty offset plus one
// - Empty raises output ready, read enable ignored
// - Output ready three stages, input ready two
// - Offsets load one of eight defaults
// - Load select at reset picks serial/parallel
// - Offsets read back only on data out
// - Offsets programmable after reset, zero to capacity-1
// - Synchronous almost flags follow own clock only
// - Asynchronous almost flags set/clear across clocks
// - Defaults decoded from load and select pins
// - Fall-through select is only latched into status; fall-through mode is always on
// - First word shows after three read edges
`timescale 1ns/1ps
`include "fwff_params.svh"
module fwff_core (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               ce,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire fwff_pkg::fwff_bus_t pwdata,
  output fwff_pkg::fwff_bus_t     prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               wclk,
  input  wire logic               wen_n,
  input  wire fwff_pkg::fwff_word_t din,
  input  wire logic               rclk,
  input  wire logic               ren_n,
  input  wire logic               offset_read_n,
  input  wire logic               master_reset_n,
  input  wire logic               fall_through_select,
  input  wire logic               load_select_n,
  input  wire logic               offset_select_0,
  input  wire logic               offset_select_1,
  input  wire logic               flag_timing_select,
  output fwff_pkg::fwff_word_t    data_out,
  output logic                    output_ready_n,
  output logic                    input_ready_n,
  output logic                    half_full_n,
  output logic                    almost_empty_n,
  output logic                    almost_full_n
);
  import fwff_pkg::*;

  // Every pin level but the two link clocks passes the two-flop synchroniser
  localparam int SW = `FWFF_SYNC_W;
  logic [SW-1:0] pins_raw;  // Pins as they arrive
  logic [SW-1:0] pins_s;    // Pins in the pclk domain
  assign pins_raw = {din, wen_n, ren_n, offset_read_n, master_reset_n,
                     fall_through_select, load_select_n, offset_select_0,
                     offset_select_1, flag_timing_select};

  fwff_sync #(.W(SW)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       (pins_raw),
    .q       (pins_s)
  );

  // Named views of the synchronised pins
  fwff_word_t din_s;   // Write data
  logic       wen_s;   // Write enable, low active
  logic       ren_s;   // Read enable, low active
  logic       ord_s;   // Offset read request, low active
  logic       run_s;   // Master reset released
  logic       fts_s;   // Fall-through strap
  logic       ld_s;    // Load strap, high means serial
  logic       fs0_s;   // Offset select 0
  logic       fs1_s;   // Offset select 1
  logic       pfm_s;   // Flag timing strap
  assign din_s = pins_s[26:9];
  assign wen_s = pins_s[8];
  assign ren_s = pins_s[7];
  assign ord_s = pins_s[6];
  assign run_s = pins_s[5];
  assign fts_s = pins_s[4];
  assign ld_s  = pins_s[3];
  assign fs0_s = pins_s[2];
  assign fs1_s = pins_s[1];
  assign pfm_s = pins_s[0];

  // Link clocks are sampled; their edges become pulses
  fwff_evt_if wevt ();
  fwff_evt_if revt ();

  fwff_edge u_wedge (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .clk_pin (wclk),
    .evt     (wevt.src)
  );

  fwff_edge u_redge (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .clk_pin (rclk),
    .evt     (revt.src)
  );

  // Storage and state
  fwff_word_t mem [0:`FWFF_DEPTH-1];  // Memory words, output register apart
  fwff_ptr_t  wptr_q;                 // Next memory slot to write
  fwff_ptr_t  rptr_q;                 // Next memory slot to read
  fwff_cnt_t  mcnt_q;                 // Words in memory
  logic       ov_q;                   // Output register holds a word
  logic       st1_q;                  // First fall-through stage
  logic       st2_q;                  // Second fall-through stage
  logic       fts_q;                  // Fall-through mode latched
  logic       ser_q;                  // Serial load method latched
  logic       pfm_q;                  // Synchronous almost flags latched
  fwff_cnt_t  eofs_q;                 // Empty offset n
  fwff_cnt_t  fofs_q;                 // Full offset m
  logic       osel_q;                 // Next offset shown: 0 empty, 1 full
  logic       ir1_q;                  // First input ready stage

  // Output flops
  fwff_word_t data_out_q;
  logic       or_n_q;
  logic       ir_n_q;
  logic       hf_n_q;
  logic       ae_n_q;
  logic       af_n_q;
  fwff_bus_t  prdata_q;
  logic       pready_q;
  logic       pslverr_q;

  assign data_out       = data_out_q;
  assign output_ready_n = or_n_q;
  assign input_ready_n  = ir_n_q;
  assign half_full_n    = hf_n_q;
  assign almost_empty_n = ae_n_q;
  assign almost_full_n  = af_n_q;
  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;

  // Eight default offset pairs; empty and full share the value
  function automatic fwff_cnt_t def_ofs(input logic [2:0] key);
    fwff_cnt_t v;
    v = `FWFF_DEF_LLL;
    unique case (key)
      3'b001: v = `FWFF_DEF_LLH;
      3'b010: v = `FWFF_DEF_LHL;
      3'b011: v = `FWFF_DEF_LHH;
      3'b101: v = `FWFF_DEF_HLH;
      3'b100: v = `FWFF_DEF_HLL;
      3'b110: v = `FWFF_DEF_HHL;
      3'b111: v = `FWFF_DEF_HHH;
      3'b000: v = `FWFF_DEF_LLL;
    endcase
    return v;
  endfunction

  // Memory full also covers an idle output register, so no word is lost
  logic      full;      // No room for a write
  logic      mem_nz;    // Memory holds a word
  logic      wr_go;     // Word taken this cycle
  logic      ofs_rd;    // Offset shown on this read edge
  logic      fill;      // Word moves into the output register
  logic      drop;      // Output register empties
  logic      ov_d;      // Next output register state
  fwff_cnt_t mcnt_d;    // Next memory count
  fwff_cnt_t tot_q;     // Words held now
  fwff_cnt_t tot_d;     // Words held after this cycle
  logic      hf_hit;    // Half-full threshold reached
  logic      af_hit;    // Almost-full threshold reached
  logic      ae_hit;    // At or below almost-empty threshold
  assign full   = (mcnt_q == `FWFF_DEPTH);
  assign mem_nz = (mcnt_q != '0);
  assign wr_go  = wevt.rise & ~wen_s & ~full & run_s;
  assign ofs_rd = revt.rise & ~ord_s & run_s;
  assign fill   = revt.rise & run_s & ~ofs_rd & st2_q & mem_nz & (~ov_q | ~ren_s);
  assign drop   = revt.rise & run_s & ~ofs_rd & ov_q & ~ren_s & ~fill;
  assign ov_d   = fill | (ov_q & ~drop);
  assign mcnt_d = fwff_cnt_t'(mcnt_q + {9'h000, wr_go} - {9'h000, fill});
  assign tot_q  = fwff_cnt_t'(mcnt_q + {9'h000, ov_q});
  assign tot_d  = fwff_cnt_t'(mcnt_d + {9'h000, ov_d});
  assign hf_hit = (tot_d >= `FWFF_HALF);
  assign af_hit = (tot_d >= fwff_cnt_t'(`FWFF_CAP - fofs_q));
  assign ae_hit = (tot_d <= fwff_cnt_t'(eofs_q + 10'd1));

  // Register bus decode
  logic hit_st;   // Status word addressed
  logic hit_eo;   // Empty offset addressed
  logic hit_fo;   // Full offset addressed
  logic adr_ok;   // Any mapped address
  logic setup;    // Setup phase of a transfer
  logic bus_wr;   // Write takes effect now
  logic ofs_ok;   // Written offset is legal
  assign hit_st = (paddr == `FWFF_ADR_STATUS);
  assign hit_eo = (paddr == `FWFF_ADR_EOFS);
  assign hit_fo = (paddr == `FWFF_ADR_FOFS);
  assign adr_ok = hit_st | hit_eo | hit_fo;
  assign setup  = psel & ~penable;
  assign bus_wr = psel & penable & pready_q & pwrite & adr_ok;
  assign ofs_ok = (pwdata[31:10] == 22'h000000) & (pwdata[9:0] <= `FWFF_OFS_MAX);

  // Straps and defaults are caught while master reset is held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fts_q  <= 1'b0;
      ser_q  <= 1'b0;
      pfm_q  <= 1'b0;
      eofs_q <= `FWFF_RST_OFS;
      fofs_q <= `FWFF_RST_OFS;
    end else if (ce) begin
      if (!run_s) begin
        fts_q  <= fts_s;
        ser_q  <= ld_s;
        pfm_q  <= pfm_s;
        eofs_q <= def_ofs({ld_s, fs0_s, fs1_s});
        fofs_q <= def_ofs({ld_s, fs0_s, fs1_s});
      end else if (bus_wr && ofs_ok) begin
        // Either load method may reprogram; illegal values are dropped
        if (hit_eo) begin
          eofs_q <= pwdata[9:0];
        end
        if (hit_fo) begin
          fofs_q <= pwdata[9:0];
        end
      end
    end
  end

  // Memory array has no reset; only written words are ever read
  always_ff @(posedge pclk) begin
    if (ce && wr_go) begin
      mem[wptr_q] <= din_s;
    end
  end

  // Pointers and memory count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_q <= '0;
      rptr_q <= '0;
      mcnt_q <= '0;
    end else if (ce) begin
      if (!run_s) begin
        wptr_q <= '0;
        rptr_q <= '0;
        mcnt_q <= '0;
      end else begin
        wptr_q <= wptr_q + fwff_ptr_t'(wr_go);
        rptr_q <= rptr_q + fwff_ptr_t'(fill);
        mcnt_q <= mcnt_d;
      end
    end
  end

  // Fall-through stages: two read edges of notice, the third loads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st1_q  <= 1'b0;
      st2_q  <= 1'b0;
      ov_q   <= 1'b0;
      or_n_q <= 1'b1;
    end else if (ce) begin
      if (!run_s) begin
        st1_q  <= 1'b0;
        st2_q  <= 1'b0;
        ov_q   <= 1'b0;
        or_n_q <= 1'b1;
      end else begin
        if (revt.rise) begin
          st1_q <= mem_nz;
          st2_q <= st1_q;
        end
        ov_q   <= ov_d;
        or_n_q <= ~ov_d;
      end
    end
  end

  // Data out shows the head word, or an offset on request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_out_q <= `FWFF_RST_WORD;
      osel_q     <= 1'b0;
    end else if (ce) begin
      if (!run_s) begin
        osel_q <= 1'b0;
      end else if (ofs_rd) begin
        // A head word already in the output register stays counted but is overwritten by the offset
        data_out_q <= fwff_word_t'(osel_q ? fofs_q : eofs_q);
        osel_q     <= ~osel_q;
      end else if (fill) begin
        data_out_q <= mem[rptr_q];
      end
    end
  end

  // Input ready: two write-edge stages after the full state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir1_q  <= 1'b1;
      ir_n_q <= 1'b1;
    end else if (ce) begin
      if (!run_s) begin
        ir1_q  <= 1'b1;
        ir_n_q <= 1'b1;
      end else if (wevt.rise) begin
        ir1_q  <= (mcnt_d == `FWFF_DEPTH);
        ir_n_q <= ir1_q;
      end
    end
  end

  // Half-full follows the count every cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hf_n_q <= 1'b1;
    end else if (ce) begin
      hf_n_q <= ~(run_s & hf_hit);
    end
  end

  // Almost-full: sync uses write edges only, async clears on reads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      af_n_q <= 1'b1;
    end else if (ce) begin
      if (!run_s) begin
        af_n_q <= 1'b1;
      end else if (pfm_q) begin
        if (wevt.rise) begin
          af_n_q <= ~af_hit;
        end
      end else if (wevt.rise && af_hit) begin
        af_n_q <= 1'b0;
      end else if (revt.rise && !af_hit) begin
        af_n_q <= 1'b1;
      end
    end
  end

  // Almost-empty: sync uses read edges only, async clears on writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ae_n_q <= 1'b0;
    end else if (ce) begin
      if (!run_s) begin
        ae_n_q <= 1'b0;
      end else if (pfm_q) begin
        if (revt.rise) begin
          ae_n_q <= ~ae_hit;
        end
      end else if (revt.rise && ae_hit) begin
        ae_n_q <= 1'b0;
      end else if (wevt.rise && !ae_hit) begin
        ae_n_q <= 1'b1;
      end
    end
  end

  // Status word: flags, latched straps and held word count
  fwff_bus_t stat_w;
  assign stat_w = {6'h00, tot_q, 8'h00, pfm_q, ser_q, fts_q,
                   ir_n_q, af_n_q, hf_n_q, ae_n_q, or_n_q};

  // Bus slave: one wait-free access cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= `FWFF_RST_BUS;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      pready_q  <= setup;
      pslverr_q <= setup & ~adr_ok;
      if (setup) begin
        // Offsets read as zero here; they are seen only on data out
        prdata_q <= (hit_st && !pwrite) ? stat_w : `FWFF_RST_BUS;
      end
    end
  end

endmodule

// ### core/fwff_params.svh
`ifndef FWFF_PARAMS_SVH
`define FWFF_PARAMS_SVH
// Data path and storage
`define FWFF_DW      18
`define FWFF_AW      9
`define FWFF_CW      10
`define FWFF_DEPTH   10'd512
`define FWFF_CAP     10'd513
`define FWFF_HALF    10'd258
`define FWFF_OFS_MAX 10'd512
// Pin synchroniser width: data plus nine control pins
`define FWFF_SYNC_W  27
// Register byte addresses
`define FWFF_ADR_STATUS 8'h00
`define FWFF_ADR_EOFS   8'h04
`define FWFF_ADR_FOFS   8'h08
// Reset values
`define FWFF_RST_OFS  10'd127
`define FWFF_RST_WORD 18'h00000
`define FWFF_RST_BUS  32'h00000000
// Default offsets by {load, select 0, select 1}
`define FWFF_DEF_LLH 10'd511
`define FWFF_DEF_LHL 10'd255
`define FWFF_DEF_LHH 10'd63
`define FWFF_DEF_HLH 10'd15
`define FWFF_DEF_HLL 10'd31
`define FWFF_DEF_HHL 10'd7
`define FWFF_DEF_HHH 10'd3
`define FWFF_DEF_LLL 10'd127
`endif

// ### core/fwff_pkg.sv
`include "fwff_params.svh"
package fwff_pkg;
  typedef logic [`FWFF_DW-1:0] fwff_word_t;
  typedef logic [`FWFF_AW-1:0] fwff_ptr_t;
  typedef logic [`FWFF_CW-1:0] fwff_cnt_t;
  typedef logic [31:0]         fwff_bus_t;
endpackage

// ### core/fwff_evt_if.sv
`timescale 1ns/1ps
// Edge events of a sampled link clock
interface fwff_evt_if;
  logic rise;  // One-cycle pulse per rising edge
  modport src (output rise);
  modport dst (input rise);
endinterface

// ### core/fwff_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for a bundle of pin levels
module fwff_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;  // First stage, read only by q
  // Both stages freeze with the clock enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ### core/fwff_edge.sv
`timescale 1ns/1ps
// Samples a link clock pin and reports its rising edges
module fwff_edge (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic clk_pin,
  fwff_evt_if.src   evt
);
  logic s1_q;  // Metastable stage
  logic s2_q;  // Settled level
  logic s3_q;  // Previous settled level
  // Third flop gives the edge without touching the first stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else if (ce) begin
      s1_q <= clk_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // Gated by ce so a frozen block sees no event
  assign evt.rise = ce & s2_q & ~s3_q;
endmodule

// ### verification/fwff_core_chk.sv
`timescale 1ns/1ps
// Port-level watch on the bus slave and the link-side outputs
module fwff_chk (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic [7:0]           paddr,
  input wire fwff_pkg::fwff_bus_t  prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 wclk,
  input wire logic                 rclk,
  input wire logic                 master_reset_n,
  input wire fwff_pkg::fwff_word_t data_out,
  input wire logic                 output_ready_n,
  input wire logic                 input_ready_n,
  input wire logic                 almost_empty_n,
  input wire logic                 almost_full_n
);
  import fwff_pkg::*;
  wire setup_w = psel && !penable;  // Setup cycle of a transfer
  wire bad_w   = paddr >= 8'h0c;    // Past the last register
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Output ready, input ready and data out may only move a few cycles after their own link clock rose
  a_ready_next: assert property (setup_w |=> pready)
    else $error("no answer in the cycle after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_unmapped: assert property (setup_w && bad_w |=> pslverr)
    else $error("unmapped address not refused");
  a_err_paired: assert property (pslverr |-> pready && penable)
    else $error("pslverr outside an access cycle");
  a_rdata_hold: assert property (!$stable(prdata) |-> $past(setup_w))
    else $error("read data moved without a setup");
  a_or_rclk: assert property (master_reset_n && !$stable(output_ready_n)
    |-> $past(rclk, 2) && !$past(rclk, 7)) else $error("output ready moved off a read edge");
  a_ir_wclk: assert property (master_reset_n && !$stable(input_ready_n)
    |-> $past(wclk, 2) && !$past(wclk, 7)) else $error("input ready moved off a write edge");
  a_data_rclk: assert property (master_reset_n && !$stable(data_out)
    |-> $past(rclk, 2) && !$past(rclk, 7)) else $error("data out moved off a read edge");
  c_refused: cover property (pslverr);
  c_full: cover property ($rose(input_ready_n));
  c_almost_full: cover property ($fell(almost_full_n));
  c_filling: cover property ($rose(almost_empty_n));
endmodule
bind fwff_core fwff_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .wclk(wclk), .rclk(rclk), .master_reset_n(master_reset_n),
  .data_out(data_out), .output_ready_n(output_ready_n), .input_ready_n(input_ready_n),
  .almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n));

// ### verification/fwff_link_model.sv
`timescale 1ns/1ps
// Writer and reader beyond the link pins, each on a free-running clock
module fwff_link_model (
  output logic                      wclk,
  output logic                      wen_n,
  output fwff_pkg::fwff_word_t      din,
  output logic                      rclk,
  output logic                      ren_n,
  output logic                      offset_read_n,
  input  wire fwff_pkg::fwff_word_t data_out,
  input  wire logic                 output_ready_n
);
  import fwff_pkg::*;
  logic       wr_go = 1'b0;   // Writer has words to send
  logic       rd_go = 1'b0;   // Reader wants words
  logic       ofs_go = 1'b0;  // Reader wants an offset shown
  fwff_word_t wdat_q = '0;    // Next word sent, counts up from zero
  fwff_word_t got[$];         // Words taken, in order
  initial begin
    wclk = 1'b0;
    rclk = 1'b0;
  end
  // Phases kept off every bus clock edge, 200 ns periods
  initial begin
    #11;
    forever #100 wclk = ~wclk;
  end
  initial begin
    #47;
    forever #100 rclk = ~rclk;
  end
  // Launch on the falling edge so pins are settled at the rise
  always @(negedge wclk or posedge wr_go) begin
    wen_n  <= !wr_go || wclk;
    din    <= wr_go ? wdat_q : ~din;     // Idle data keeps toggling
    if (wr_go && !wclk) begin
      wdat_q <= wdat_q + 1'b1;
    end
  end
  always @(negedge rclk) begin
    ren_n         <= !rd_go;
    offset_read_n <= !ofs_go;
  end
  // A valid head word is taken at each rise with read enable low
  always @(posedge rclk) begin
    if (ren_n === 1'b0 && output_ready_n === 1'b0) begin
      got.push_back(data_out);
    end
  end
  task automatic write_words(input int n);
    @(posedge wclk);
    wr_go = (n > 0);
    repeat (n) @(posedge wclk);
    wr_go = 1'b0;
  endtask
  task automatic read_words(input int n);
    @(posedge rclk);
    rd_go = 1'b1;
    repeat (n) @(posedge rclk);
    rd_go = 1'b0;
  endtask
  // Returns one rise after the offset landed on the data pins
  task automatic read_offset();
    @(posedge rclk);
    ofs_go = 1'b1;
    @(posedge rclk);
    ofs_go = 1'b0;
    @(posedge rclk);
  endtask
endmodule

// ### verification/fwft_fifo_flags_offsets_tb_top.sv
`timescale 1ns/1ps
`include "fwff_params.svh"
module fwft_fifo_flags_offsets_tb_top;
  import fwff_pkg::*;
  logic       pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;  // Bus side
  logic [7:0] paddr;                                                  // Byte address
  fwff_bus_t  pwdata, prdata;                                         // Bus data
  logic       wclk, wen_n, rclk, ren_n, offset_read_n;                // Link pins
  fwff_word_t din, data_out;                                          // Link data
  logic       master_reset_n, fall_through_select, load_select_n;     // Reset and straps
  logic       offset_select_0, offset_select_1, flag_timing_select;   // More straps
  logic       output_ready_n, input_ready_n, half_full_n, almost_empty_n, almost_full_n;
  int         err_count = 0;                                          // Mismatches
  int         num_checks = 0;                                         // Comparisons
  int         cyc = 0;                                                // Cycles run
  fwff_link_model link (.wclk(wclk), .wen_n(wen_n), .din(din), .rclk(rclk), .ren_n(ren_n),
    .offset_read_n(offset_read_n), .data_out(data_out), .output_ready_n(output_ready_n));
  fwff_core dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wclk(wclk),
    .wen_n(wen_n), .din(din), .rclk(rclk), .ren_n(ren_n), .offset_read_n(offset_read_n),
    .master_reset_n(master_reset_n), .fall_through_select(fall_through_select), .load_select_n(load_select_n),
    .offset_select_0(offset_select_0), .offset_select_1(offset_select_1), .flag_timing_select(flag_timing_select),
    .data_out(data_out), .output_ready_n(output_ready_n), .input_ready_n(input_ready_n),
    .half_full_n(half_full_n), .almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // A hang counts as a mismatch; the run needs about 11000 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One bus transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input fwff_bus_t wd, output fwff_bus_t rd, output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd = prdata;
    e  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    check("pready", 32'd1, 32'(pready));
  endtask
  // Straps {fall-through, load, select 0, select 1, flag timing}
  task automatic mreset(input logic [4:0] s);
    int n;
    @(posedge pclk);
    master_reset_n <= 1'b0;
    {fall_through_select, load_select_n, offset_select_0, offset_select_1, flag_timing_select} <= s;
    repeat (8) @(posedge pclk);
    master_reset_n <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (input_ready_n !== 1'b0 && n < 200);
    check("room after reset", 32'd0, 32'(input_ready_n));
  endtask
  // Expected {ir, af, hf, ae, or} for k words held, counting the output register
  function automatic logic [4:0] flags(input int k, input int n, input int m);
    return {k >= `FWFF_CAP, k < `FWFF_CAP - m, k < `FWFF_HALF, k >= n + 2, k == 0};
  endfunction
  task automatic wait_status(input int k, input int n, input int m);
    fwff_bus_t   v;
    logic        e;
    logic [14:0] exp;
    int          i;
    exp = {10'(k), flags(k, n, m)};
    for (i = 0; i < 200; i++) begin
      apb(1'b0, `FWFF_ADR_STATUS, '0, v, e);
      if ({v[25:16], v[4:0]} === exp) break;
    end
    check("status", 32'(exp), 32'({v[25:16], v[4:0]}));
    check("flag pins", 32'(exp[4:0]), 32'({input_ready_n, almost_full_n, half_full_n, almost_empty_n,
      output_ready_n}));
  endtask
  task automatic t_defaults();
    int        defs[8];
    fwff_bus_t v;
    logic      e;
    int        i;
    defs = '{`FWFF_DEF_LLL, `FWFF_DEF_LLH, `FWFF_DEF_LHL, `FWFF_DEF_LHH,
             `FWFF_DEF_HLL, `FWFF_DEF_HLH, `FWFF_DEF_HHL, `FWFF_DEF_HHH};
    for (i = 0; i < 8; i++) begin
      mreset({1'b1, 3'(i), i[0]});
      link.read_offset();
      check("empty default", 32'(defs[i]), 32'(data_out));
      link.read_offset();
      check("full default", 32'(defs[i]), 32'(data_out));
      apb(1'b0, `FWFF_ADR_STATUS, '0, v, e);
      check("straps", {29'h0, i[0], i[2], 1'b1}, 32'(v[7:5]));
    end
  endtask
  task automatic t_program();
    fwff_bus_t v;
    logic      e;
    mreset(5'b10001);
    apb(1'b1, `FWFF_ADR_EOFS, 32'd5, v, e);
    apb(1'b1, `FWFF_ADR_FOFS, 32'd9, v, e);
    apb(1'b1, `FWFF_ADR_EOFS, 32'd513, v, e);
    apb(1'b1, 8'h0c, 32'd1, v, e);
    check("unmapped error", 32'd1, 32'(e));
    apb(1'b0, `FWFF_ADR_EOFS, '0, v, e);
    check("offset port reads", 32'd0, v);
    link.read_offset();
    check("empty offset", 32'd5, 32'(data_out));
    link.read_offset();
    check("full offset", 32'd9, 32'(data_out));
  endtask
  // Fill past every threshold with n=5, m=9, then push two words into a full FIFO
  task automatic t_fill();
    int ks[9];
    int k;
    int i;
    ks = '{1, 6, 7, 257, 258, 503, 504, 512, 513};
    k = 0;
    wait_status(0, 5, 9);
    for (i = 0; i < 9; i++) begin
      link.write_words(ks[i] - k);
      k = ks[i];
      wait_status(k, 5, 9);
    end
    check("first word", 32'd0, 32'(data_out));
    link.write_words(2);
    wait_status(513, 5, 9);
  endtask
  task automatic t_drain();
    int ks[9];
    int k;
    int i;
    ks = '{512, 504, 503, 258, 257, 7, 6, 1, 0};
    k = 513;
    for (i = 0; i < 9; i++) begin
      link.read_words(k - ks[i]);
      k = ks[i];
      wait_status(k, 5, 9);
    end
    link.read_words(3);
    wait_status(0, 5, 9);
    check("words taken", 32'd513, 32'(link.got.size()));
    for (i = 0; i < 513; i++) begin
      check("word order", 32'(i), 32'(link.got[i]));
    end
  endtask
  // Almost-empty set and cleared across the two clocks, default offsets of 127; frozen writes are lost
  task automatic t_async();
    mreset(5'b10000);
    ce <= 1'b0;
    link.write_words(3);
    repeat (8) @(posedge pclk);
    ce <= 1'b1;
    link.write_words(130);
    wait_status(130, 127, 127);
    link.read_words(2);
    wait_status(128, 127, 127);
    link.read_words(128);
    wait_status(0, 127, 127);
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    ce = 1'b1;
    master_reset_n = 1'b1;
    {fall_through_select, load_select_n, offset_select_0, offset_select_1, flag_timing_select} = 5'h10;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("reset flags", 32'h1d, 32'({input_ready_n, almost_full_n, half_full_n, almost_empty_n,
      output_ready_n}));
    check("reset data", 32'd0, 32'(data_out));
    t_defaults();
    t_program();
    t_fill();
    t_drain();
    t_async();
    end_sim();
  end
endmodule
